// ==== dv/hrcs_partner.sv ====
// board reset source, eeprom loader and smbus host model for the sequencer
`timescale 1ns/10ps
`default_nettype none

module hrcs_partner #(
   parameter int P_HOLD = 50
) (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_req,
   input  wire logic       i_ee_start,
   input  wire logic       i_operational,
   input  wire logic [7:0] i_dly,
   output logic            o_reset_n,
   output logic            o_ee_done,
   output logic            o_smb_done
);
   int   hold;
   int   ee_cnt;
   int   smb_cnt;
   logic op_q;
   logic req_q;

   // ---------------------------------------------------------------------
   // far side, driven after the falling edge, away from the sampling edge
   // ---------------------------------------------------------------------
   initial begin
      {o_reset_n, o_ee_done, o_smb_done, op_q, req_q} = 5'h10;
      {hold, ee_cnt, smb_cnt} = '0;
   end

   // the bench writes the request on the falling edge; taking it on the
   // rising edge keeps this model from racing the bench for it
   always @(posedge i_mclk) begin
      req_q <= i_rst_req;
   end

   always @(negedge i_mclk) begin
      // a request of any length holds the pin low for a full 1 us
      if (req_q) hold = P_HOLD;
      o_reset_n <= (hold == 0);
      if (hold > 0) hold--;
      o_ee_done  <= 1'b0;
      o_smb_done <= 1'b0;
      // done comes a set delay after the load starts; delay 0 means never
      if (ee_cnt > 0) begin
         ee_cnt--;
         if (ee_cnt == 0) o_ee_done <= 1'b1;
      end
      if (i_ee_start) ee_cnt = i_dly;
      if (smb_cnt > 0) begin
         smb_cnt--;
         if (smb_cnt == 0) o_smb_done <= 1'b1;
      end
      if (i_operational && !op_q) smb_cnt = i_dly;
      op_q = i_operational;
      // loaders give up while the pin holds the device in reset
      if (!o_reset_n) {ee_cnt, smb_cnt} = '0;
   end
endmodule : hrcs_partner

`default_nettype wire

// ==== dv/hrcs_sequencer_tb.sv ====
// self-checking bench for the hub reset and configuration sequencer
`timescale 1ns/10ps
`default_nettype none

module hrcs_sequencer_tb;
   localparam int N = 20;
   localparam int EE = 50;
   localparam int RQ = 30;
   typedef struct {
      logic [1:0] sel;
      logic [1:0] strap;
      logic [7:0] dly;
      int         lo;
      logic       ee;
      logic       to;
   } hrcs_row_t;
   // strap, eeprom, eeprom with no answer, smbus, reserved select
   hrcs_row_t rows [5] = '{
      '{2'h0, 2'h1, 8'h00, 1, 1'b0, 1'b0},
      '{2'h1, 2'h2, 8'h0A, 10, 1'b1, 1'b0},
      '{2'h1, 2'h3, 8'h00, EE, 1'b1, 1'b1},
      '{2'h2, 2'h0, 8'h28, 40, 1'b0, 1'b0},
      '{2'h3, 2'h2, 8'h00, 1, 1'b0, 1'b0}};
   logic i_mclk, i_sys_rst, i_reset_n_pin, i_ee_done, i_smb_done, rst_req;
   logic [1:0] i_cfg_sel, i_led_strap, o_strap_val;
   logic [7:0] dly, o_usb_config;
   hrcs_pkg::hrcs_hub_req_t i_hub;
   logic [3:0] o_port_power_en, o_port_enable, o_ds_reset;
   logic [4:0] o_dp_oe_n;
   logic [6:0] o_usb_addr;
   logic o_phy_enable, o_xtal_run, o_pll_run, o_led_en, o_xact_abort;
   logic o_regs_default, o_pins_driven, o_operational, o_ee_start;
   logic o_cfg_timeout, o_attach, o_suspended, o_tt_flush, o_req_overdue;
   int err_count = 0;
   int tests_run = 0;
   int pd, op, at, c;
   logic ees;

   hrcs_sequencer #(.P_RECOVER_CYC(N), .P_EE_MAX_CYC(EE),
      .P_REQ_MAX_CYC(RQ)) dut (.i_mclk, .i_sys_rst, .i_reset_n_pin,
      .i_cfg_sel, .i_led_strap, .i_hub, .i_ee_done, .i_smb_done,
      .o_port_power_en, .o_port_enable, .o_phy_enable, .o_dp_oe_n,
      .o_xtal_run, .o_pll_run, .o_led_en, .o_xact_abort, .o_regs_default,
      .o_pins_driven, .o_strap_val, .o_operational, .o_ee_start,
      .o_cfg_timeout, .o_attach, .o_usb_addr, .o_usb_config, .o_suspended,
      .o_tt_flush, .o_ds_reset, .o_req_overdue);

   hrcs_partner #(.P_HOLD(50)) far (.i_mclk, .i_rst_req(rst_req),
      .i_ee_start(o_ee_start), .i_operational(o_operational), .i_dly(dly),
      .o_reset_n(i_reset_n_pin), .o_ee_done(i_ee_done),
      .o_smb_done(i_smb_done));

   // ---------------------------------------------------------------------
   // clock, shared tasks and watchdog
   // ---------------------------------------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   // everything safe and quiet while hardware reset holds
   task automatic chk_rst();
      chk("port_power", {o_port_power_en, o_port_enable}, 8'h00);
      chk("phy_pairs", {o_phy_enable, o_dp_oe_n}, 6'h1F);
      chk("xact_abort", o_xact_abort, 1'b1);
      chk("regs_dflt", {o_regs_default, o_usb_addr, o_usb_config},
          16'h8000);
      chk("clk_led", {o_xtal_run, o_pll_run, o_led_en}, 3'h0);
      chk("no_attach", {o_attach, o_cfg_timeout}, 2'h0);
   endtask : chk_rst

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      $display("CHECK FAILED watchdog expected done seen hang");
      test_done();
   end

   // ---------------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------------
   initial begin
      {i_sys_rst, rst_req, i_cfg_sel, i_led_strap, dly} = 14'h2000;
      i_hub = '0;
      repeat (2) @(negedge i_mclk);
      chk_rst();
      i_sys_rst = 1'b0;
      // one row per configuration path; pin reset, release, count events
      foreach (rows[r]) begin
         {i_cfg_sel, i_led_strap, dly} = {rows[r].sel, rows[r].strap,
                                          rows[r].dly};
         rst_req = 1'b1;
         repeat (2) @(negedge i_mclk);
         rst_req = 1'b0;
         repeat (10) @(negedge i_mclk);
         chk_rst();
         for (c = 0; c < 100 && !i_reset_n_pin; c++) @(negedge i_mclk);
         {pd, op, at, ees} = '0;
         for (c = 1; c < 400 && at == 0; c++) begin
            @(negedge i_mclk);
            // straps must be caught at release, not followed later
            if (c == 20) i_led_strap = ~rows[r].strap;
            if (o_pins_driven && pd == 0) pd = c;
            if (o_operational && op == 0) op = c;
            if (o_ee_start) ees = 1'b1;
            if (o_attach) at = c;
         end
         chk("pins_driven", pd > 0 && pd <= 100, 1'b1);
         chk("strap_val", o_strap_val, rows[r].strap);
         chk("op_time", op >= N && op <= N + 4, 1'b1);
         chk("run_en", {o_phy_enable, o_xtal_run, o_pll_run, o_led_en},
             4'hF);
         chk("ee_start", ees, rows[r].ee);
         chk("attach_time", at - op >= rows[r].lo && at - op <= rows[r].lo
             + 3, 1'b1);
         chk("up_drive", o_dp_oe_n[0], 1'b0);
         chk("cfg_timeout", o_cfg_timeout, rows[r].to);
      end
      // host waits after attach before any request or bus reset
      repeat (50) @(negedge i_mclk);
      i_hub.req_start = 1'b1;
      @(negedge i_mclk);
      i_hub = '0;
      for (c = 1; c < 40 && !o_req_overdue; c++) @(negedge i_mclk);
      chk("req_overdue", c >= RQ && c <= RQ + 3, 1'b1);
      i_hub.req_start = 1'b1;
      @(negedge i_mclk);
      chk("overdue_clr", o_req_overdue, 1'b0);
      i_hub = '0;
      repeat (5) @(negedge i_mclk);
      i_hub.req_done = 1'b1;
      @(negedge i_mclk);
      i_hub = '0;
      repeat (RQ + 5) @(negedge i_mclk);
      chk("req_in_time", o_req_overdue, 1'b0);
      // configure, power ports, suspend, then bus reset with downstream held
      {i_hub.set_addr, i_hub.addr, i_hub.set_cfg, i_hub.cfg} = 17'h15501;
      {i_hub.pwr_on, i_hub.suspend, i_hub.ds_reset} = 9'h1F5;
      @(negedge i_mclk);
      {i_hub.set_addr, i_hub.set_cfg, i_hub.pwr_on, i_hub.suspend} = '0;
      @(negedge i_mclk);
      chk("addr_cfg", {o_usb_addr, o_usb_config}, 15'h2A01);
      chk("powered", {o_port_power_en, o_port_enable, o_dp_oe_n},
          13'h1FE0);
      chk("susp_ds", {o_suspended, o_ds_reset}, 5'h15);
      i_hub.bus_reset = 1'b1;
      @(negedge i_mclk);
      i_hub = '0;
      chk("bus_ds", o_ds_reset, 4'h0);
      chk("bus_addr", o_usb_addr, 7'h00);
      chk("bus_cfg", o_usb_config, 8'h00);
      chk("bus_pwr", {o_port_power_en, o_port_enable}, 8'h00);
      chk("bus_tt", o_tt_flush, 1'b1);
      chk("bus_susp", o_suspended, 1'b0);
      @(negedge i_mclk);
      chk("tt_pulse", {o_tt_flush, o_attach}, 2'h1);
      // power up and suspend, then switch two ports off and resume
      {i_hub.pwr_on, i_hub.suspend} = 5'h1F;
      @(negedge i_mclk);
      {i_hub.pwr_on, i_hub.suspend, i_hub.pwr_off, i_hub.resume} = 10'h007;
      @(negedge i_mclk);
      i_hub = '0;
      chk("pwr_off_resume", {o_port_power_en, o_suspended}, 5'h18);
      // pin reset in mid-run with ports powered must drop everything
      rst_req = 1'b1;
      @(negedge i_mclk);
      rst_req = 1'b0;
      repeat (4) @(negedge i_mclk);
      chk_rst();
      test_done();
   end
endmodule : hrcs_sequencer_tb

`default_nettype wire

// ==== rtl/hrcs_cfg.svh ====
// timing, field widths and default values for the reset/config sequencer
`ifndef HRCS_CFG_SVH
`define HRCS_CFG_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define HRCS_CLK_KHZ        50000

// ----------------------------------------------------------------------
// times in their own units, then cycle counts derived from them
// ----------------------------------------------------------------------
`define HRCS_RECOVER_US     500
`define HRCS_DRIVE_MAX_US   2
`define HRCS_EE_MAX_MS10    995
`define HRCS_ATTACH_MAX_MS  100
`define HRCS_REQ_MAX_MS     5
// longest times round down
`define HRCS_RECOVER_CYC   ((`HRCS_RECOVER_US * `HRCS_CLK_KHZ) / 1000)
`define HRCS_DRIVE_MAX_CYC ((`HRCS_DRIVE_MAX_US * `HRCS_CLK_KHZ) / 1000)
`define HRCS_EE_MAX_CYC    ((`HRCS_EE_MAX_MS10 * `HRCS_CLK_KHZ) / 10)
`define HRCS_ATTACH_MAX_CYC (`HRCS_ATTACH_MAX_MS * `HRCS_CLK_KHZ)
`define HRCS_REQ_MAX_CYC   (`HRCS_REQ_MAX_MS * `HRCS_CLK_KHZ)

// ----------------------------------------------------------------------
// default register values and field widths
// ----------------------------------------------------------------------
`define HRCS_ADDR_DFLT      7'h00
`define HRCS_CFG_DFLT       8'h00
`define HRCS_CNT_W          23
`define HRCS_REQ_W          18
`define HRCS_PORTS          4

`endif

// ==== rtl/hrcs_pkg.sv ====
// types shared by the reset/config sequencer
package hrcs_pkg;

   // ---------------------------------------------------------------------
   // sequencer states and configuration modes
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      HRCS_HW_RST   = 3'b000,
      HRCS_RECOVER  = 3'b001,
      HRCS_EE_LOAD  = 3'b010,
      HRCS_SMB_WAIT = 3'b011,
      HRCS_ATTACH   = 3'b100,
      HRCS_RUN      = 3'b101
   } hrcs_state_t;

   // select pins: 11 falls back to strap mode
   typedef enum logic [1:0] {
      HRCS_MODE_STRAP  = 2'b00,
      HRCS_MODE_EEPROM = 2'b01,
      HRCS_MODE_SMBUS  = 2'b10,
      HRCS_MODE_RSVD   = 2'b11
   } hrcs_mode_t;

   // ---------------------------------------------------------------------
   // requests from the hub core (same clock, one-cycle pulses)
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic       bus_reset;
      logic       set_addr;
      logic [6:0] addr;
      logic       set_cfg;
      logic [7:0] cfg;
      logic       suspend;
      logic       resume;
      logic [3:0] pwr_on;
      logic [3:0] pwr_off;
      logic [3:0] ds_reset;
      logic       req_start;
      logic       req_done;
   } hrcs_hub_req_t;

   // ---------------------------------------------------------------------
   // whole control state; all-zero is the hardware reset value
   // ---------------------------------------------------------------------
   typedef struct packed {
      hrcs_state_t state;
      logic [22:0] cnt;
      hrcs_mode_t  mode;
      logic [1:0]  strap;
      logic        alive;
      logic        operational;
      logic        phy_en;
      logic        xtal_run;
      logic        pll_run;
      logic        led_en;
      logic        ee_start;
      logic        cfg_timeout;
      logic        attach;
      logic        suspended;
      logic        tt_flush;
      logic [3:0]  pwr;
      logic [3:0]  port_en;
      logic [3:0]  ds_reset;
      logic [6:0]  addr;
      logic [7:0]  cfg;
      logic        req_busy;
      logic [17:0] req_cnt;
      logic        req_overdue;
   } hrcs_ctl_t;

endpackage : hrcs_pkg

// ==== rtl/hrcs_sequencer.sv ====
// hub hardware-reset, configuration and bus-reset sequencer
`timescale 1ns/10ps
`default_nettype none
`include "hrcs_cfg.svh"

// Contract
// - reset disables ports, drops port power
// - reset disables phys, pairs high impedance
// - reset aborts transactions, keeps no state
// - reset returns registers to defaults
// - reset stops oscillator, pll, leds
// - operational within 500 us of release
// - eeprom mode starts eeprom read immediately
// - strap mode drives outputs within 2 us
// - eeprom load finishes within 99.5 ms
// - attach within 100 ms of config
// - each host request done within 5 ms
// - bus reset never forwarded downstream
// - bus reset clears device address
// - bus reset returns to unconfigured
// - bus reset drops all port power
// - bus reset flushes translator buffers
// - bus reset wakes from suspend
// - strap mode samples led pins after release
// - smbus mode waits without limit for load done, then attaches
module hrcs_sequencer #(
   parameter int unsigned P_RECOVER_CYC = `HRCS_RECOVER_CYC,
   parameter int unsigned P_EE_MAX_CYC  = `HRCS_EE_MAX_CYC,
   parameter int unsigned P_REQ_MAX_CYC = `HRCS_REQ_MAX_CYC
) (
   input  wire logic                   i_mclk,
   input  wire logic                   i_sys_rst,
   input  wire logic                   i_reset_n_pin,
   input  wire logic [1:0]             i_cfg_sel,
   input  wire logic [1:0]             i_led_strap,
   input  wire hrcs_pkg::hrcs_hub_req_t i_hub,
   input  wire logic                   i_ee_done,
   input  wire logic                   i_smb_done,
   output logic [3:0]                  o_port_power_en,
   output logic [3:0]                  o_port_enable,
   output logic                        o_phy_enable,
   output logic [4:0]                  o_dp_oe_n,
   output logic                        o_xtal_run,
   output logic                        o_pll_run,
   output logic                        o_led_en,
   output logic                        o_xact_abort,
   output logic                        o_regs_default,
   output logic                        o_pins_driven,
   output logic [1:0]                  o_strap_val,
   output logic                        o_operational,
   output logic                        o_ee_start,
   output logic                        o_cfg_timeout,
   output logic                        o_attach,
   output logic [6:0]                  o_usb_addr,
   output logic [7:0]                  o_usb_config,
   output logic                        o_suspended,
   output logic                        o_tt_flush,
   output logic [3:0]                  o_ds_reset,
   output logic                        o_req_overdue
);

   localparam int DRIVE_MAX = `HRCS_DRIVE_MAX_CYC;

   // ---------------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------------
   if (P_RECOVER_CYC < 1 || P_RECOVER_CYC > (1 << `HRCS_CNT_W))
      $error("recovery count does not fit the counter");
   if (P_EE_MAX_CYC < 1 || P_EE_MAX_CYC > (1 << `HRCS_CNT_W))
      $error("eeprom load limit does not fit the counter");
   if (P_REQ_MAX_CYC < 1 || P_REQ_MAX_CYC > (1 << `HRCS_REQ_W))
      $error("request limit does not fit the watchdog");
   if (`HRCS_ATTACH_MAX_CYC < 1 || DRIVE_MAX < 1)
      $error("attach or drive limit below one cycle");

   // ---------------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------------
   logic       rstn_s1;
   logic       rstn_s2;
   logic [3:0] pins_s1;
   logic [3:0] pins_s2;
   logic       hw_rst;

   // reset pin and straps come from the board, two flops before use
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rstn_s1 <= 1'b0;
         rstn_s2 <= 1'b0;
         pins_s1 <= 4'h0;
         pins_s2 <= 4'h0;
      end else begin
         rstn_s1 <= i_reset_n_pin;
         rstn_s2 <= rstn_s1;
         pins_s1 <= {i_cfg_sel, i_led_strap};
         pins_s2 <= pins_s1;
      end
   end

   // assertion enters asynchronously via i_sys_rst; the pin costs 2 clocks
   assign hw_rst = ~rstn_s2;

   // ---------------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------------
   hrcs_pkg::hrcs_ctl_t ctl;
   hrcs_pkg::hrcs_ctl_t next_ctl;

   // next state of the whole sequencer
   always_comb begin
      next_ctl          = ctl;
      next_ctl.ee_start = 1'b0;
      next_ctl.tt_flush = 1'b0;
      next_ctl.ds_reset = 4'h0;
      if (hw_rst) begin
         // everything back to safe defaults, nothing kept
         next_ctl = '0;
      end else begin
         case (ctl.state)
            hrcs_pkg::HRCS_HW_RST: begin
               // release seen: drive pins inactive and catch straps
               next_ctl.state    = hrcs_pkg::HRCS_RECOVER;
               next_ctl.cnt      = '0;
               next_ctl.mode     = hrcs_pkg::hrcs_mode_t'(pins_s2[3:2]);
               next_ctl.strap    = pins_s2[1:0];
               next_ctl.alive    = 1'b1;
               next_ctl.xtal_run = 1'b1;
               next_ctl.pll_run  = 1'b1;
            end
            hrcs_pkg::HRCS_RECOVER: begin
               next_ctl.cnt = ctl.cnt + 23'h000001;
               if (ctl.cnt == 23'(P_RECOVER_CYC - 1)) begin
                  next_ctl.cnt         = '0;
                  next_ctl.operational = 1'b1;
                  next_ctl.phy_en      = 1'b1;
                  next_ctl.led_en      = 1'b1;
                  case (ctl.mode)
                     hrcs_pkg::HRCS_MODE_EEPROM: begin
                        next_ctl.state    = hrcs_pkg::HRCS_EE_LOAD;
                        next_ctl.ee_start = 1'b1;
                     end
                     hrcs_pkg::HRCS_MODE_SMBUS: begin
                        next_ctl.state = hrcs_pkg::HRCS_SMB_WAIT;
                     end
                     default: begin
                        next_ctl.state = hrcs_pkg::HRCS_ATTACH;
                     end
                  endcase
               end
            end
            hrcs_pkg::HRCS_EE_LOAD: begin
               // a dead eeprom must not hold the hub off the bus
               next_ctl.cnt = ctl.cnt + 23'h000001;
               if (i_ee_done) begin
                  next_ctl.state = hrcs_pkg::HRCS_ATTACH;
               end else if (ctl.cnt == 23'(P_EE_MAX_CYC - 1)) begin
                  next_ctl.cfg_timeout = 1'b1;
                  next_ctl.state       = hrcs_pkg::HRCS_ATTACH;
               end
            end
            hrcs_pkg::HRCS_SMB_WAIT: begin
               // no limit here; the host owns the load time
               if (i_smb_done) begin
                  next_ctl.state = hrcs_pkg::HRCS_ATTACH;
               end
            end
            hrcs_pkg::HRCS_ATTACH: begin
               next_ctl.attach = 1'b1;
               next_ctl.state  = hrcs_pkg::HRCS_RUN;
            end
            hrcs_pkg::HRCS_RUN: begin
               if (i_hub.bus_reset) begin
                  // upstream reset stays upstream: ds_reset held at 0
                  next_ctl.addr      = `HRCS_ADDR_DFLT;
                  next_ctl.cfg       = `HRCS_CFG_DFLT;
                  next_ctl.pwr       = 4'h0;
                  next_ctl.port_en   = 4'h0;
                  next_ctl.tt_flush  = 1'b1;
                  next_ctl.suspended = 1'b0;
                  next_ctl.req_busy  = 1'b0;
               end else begin
                  next_ctl.ds_reset = i_hub.ds_reset;
                  if (i_hub.set_addr) begin
                     next_ctl.addr = i_hub.addr;
                  end
                  if (i_hub.set_cfg) begin
                     next_ctl.cfg = i_hub.cfg;
                  end
                  if (i_hub.suspend) begin
                     next_ctl.suspended = 1'b1;
                  end else if (i_hub.resume) begin
                     next_ctl.suspended = 1'b0;
                  end
                  next_ctl.pwr     = (ctl.pwr | i_hub.pwr_on) &
                                     ~i_hub.pwr_off;
                  next_ctl.port_en = next_ctl.pwr;
                  // request watchdog: overdue flag set wins over clear
                  if (i_hub.req_start) begin
                     next_ctl.req_busy    = 1'b1;
                     next_ctl.req_cnt     = '0;
                     next_ctl.req_overdue = 1'b0;
                  end else if (ctl.req_busy) begin
                     next_ctl.req_cnt = ctl.req_cnt + 18'h00001;
                  end
                  if (i_hub.req_done) begin
                     next_ctl.req_busy = 1'b0;
                  end
                  if (ctl.req_busy && !i_hub.req_done &&
                      ctl.req_cnt == 18'(P_REQ_MAX_CYC - 1)) begin
                     next_ctl.req_overdue = 1'b1;
                  end
               end
            end
            default: begin
               next_ctl = '0;
            end
         endcase
      end
   end

   // register the control state
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctl <= '0;
      end else begin
         ctl <= next_ctl;
      end
   end

   // ---------------------------------------------------------------------
   // outputs, all straight from control flops
   // ---------------------------------------------------------------------
   assign o_port_power_en = ctl.pwr;
   assign o_port_enable   = ctl.port_en;
   assign o_phy_enable    = ctl.phy_en;
   assign o_dp_oe_n       = {~ctl.port_en, ~ctl.attach};
   assign o_xtal_run      = ctl.xtal_run;
   assign o_pll_run       = ctl.pll_run;
   assign o_led_en        = ctl.led_en;
   assign o_xact_abort    = ~ctl.alive;
   assign o_regs_default  = ~ctl.alive;
   assign o_pins_driven   = ctl.alive;
   assign o_strap_val     = ctl.strap;
   assign o_operational   = ctl.operational;
   assign o_ee_start      = ctl.ee_start;
   assign o_cfg_timeout   = ctl.cfg_timeout;
   assign o_attach        = ctl.attach;
   assign o_usb_addr      = ctl.addr;
   assign o_usb_config    = ctl.cfg;
   assign o_suspended     = ctl.suspended;
   assign o_tt_flush      = ctl.tt_flush;
   assign o_ds_reset      = ctl.ds_reset;
   assign o_req_overdue   = ctl.req_overdue;

   // ---------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   logic in_run;
   assign in_run = (ctl.state == hrcs_pkg::HRCS_RUN);

   ports_off_a: assert property (
      hw_rst |=> o_port_power_en == 4'h0 && o_port_enable == 4'h0)
      else $error("port power left on in reset");
   phy_hiz_a: assert property (
      hw_rst |=> o_dp_oe_n == 5'h1F && !o_phy_enable)
      else $error("pairs driven in reset");
   state_lost_a: assert property (
      hw_rst |=> o_xact_abort && o_usb_addr == 7'h00 &&
                 o_usb_config == 8'h00 && !o_attach)
      else $error("state kept across reset");
   clocks_off_a: assert property (
      hw_rst |=> !o_xtal_run && !o_pll_run && !o_led_en)
      else $error("clock or led running in reset");
   recover_len_a: assert property (
      $rose(o_operational) |->
         $past(ctl.state) == hrcs_pkg::HRCS_RECOVER &&
         $past(ctl.cnt) == 23'(P_RECOVER_CYC - 1))
      else $error("recovery interval wrong");
   ee_kick_a: assert property (
      $rose(o_operational) && ctl.mode == hrcs_pkg::HRCS_MODE_EEPROM
         |-> o_ee_start ##1 !o_ee_start)
      else $error("eeprom read not started");
   drive_fast_a: assert property (
      $fell(hw_rst) |-> ##[1:DRIVE_MAX] o_pins_driven)
      else $error("outputs not driven in time");
   ee_bound_a: assert property (
      ctl.state == hrcs_pkg::HRCS_EE_LOAD |->
         ctl.cnt < 23'(P_EE_MAX_CYC))
      else $error("eeprom load overran");
   attach_go_a: assert property (
      ctl.state == hrcs_pkg::HRCS_ATTACH && !hw_rst
         |=> o_attach && in_run)
      else $error("attach late");
   req_dog_a: assert property (
      in_run && ctl.req_busy && !hw_rst && !i_hub.bus_reset &&
      !i_hub.req_done && ctl.req_cnt == 18'(P_REQ_MAX_CYC - 1)
         |=> o_req_overdue)
      else $error("overdue request not flagged");
   bus_reset_a: assert property (
      in_run && i_hub.bus_reset && !hw_rst |=>
         o_ds_reset == 4'h0 && o_usb_addr == 7'h00 &&
         o_usb_config == 8'h00 && o_port_power_en == 4'h0)
      else $error("bus reset handling wrong");
   tt_wake_a: assert property (
      in_run && i_hub.bus_reset && !hw_rst |=>
         o_tt_flush && !o_suspended ##1 !o_tt_flush)
      else $error("no flush or wake on bus reset");
   strap_cap_a: assert property (
      $rose(o_pins_driven) |-> o_strap_val == $past(pins_s2[1:0]))
      else $error("strap levels not captured");
   smb_hold_a: assert property (
      ctl.state == hrcs_pkg::HRCS_SMB_WAIT && !i_smb_done |=> !o_attach)
      else $error("attached before smbus load");

   strap_run_c: cover property (
      ctl.mode == hrcs_pkg::HRCS_MODE_STRAP && $rose(in_run));
   ee_run_c: cover property (
      ctl.mode == hrcs_pkg::HRCS_MODE_EEPROM && $rose(in_run));
   smb_run_c: cover property (
      ctl.mode == hrcs_pkg::HRCS_MODE_SMBUS && $rose(in_run));
   bus_rst_c: cover property (in_run && i_hub.bus_reset && o_suspended);

endmodule : hrcs_sequencer
`default_nettype wire
